// ---- inc/prc_regs.svh ----
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH

// ==========================================================================
// Register address, layout and reset values.
// ==========================================================================
// Register-space address that selects the refresh and sleep configuration.
`define PRC_CFG1_ADDR 45'h000000000001
// Reset image; the two low bits are replaced by the grade code.
`define PRC_CFG1_RESET 16'hffc0
// Bits that a host write may change (clock type, sleep, partial refresh).
`define PRC_CFG1_WRITE_MASK 16'h007c
`define PRC_CLK_TYPE_BIT 6
`define PRC_SLEEP_BIT 5
`define PRC_PAR_MSB 4
`define PRC_PAR_LSB 2
// Partial refresh code that turns refresh off.
`define PRC_PAR_NONE 3'h4
// Refresh interval codes for the two temperature grades.
`define PRC_GRADE_LOW_CODE 2'h1
`define PRC_GRADE_HIGH_CODE 2'h2

// ==========================================================================
// Timing.
// ==========================================================================
`define PRC_SYS_CLK_MHZ 200
`define PRC_MAX_SELECT_LOW_TIME_LOW_NS 4000
`define PRC_MAX_SELECT_LOW_TIME_HIGH_NS 1000
// Link edges in the command-address phase (six bytes, one per edge).
`define PRC_CA_EDGES 8'h06
// Idle levels of the synchronised pins: select and reset pin high.
`define PRC_SYNC_RESET 13'h0600

`endif

// ---- inc/prc_pkg.sv ----
package prc_pkg;

  // ========================================================================
  // Types shared by the link logic and the write buffer.
  // ========================================================================
  // Link transaction sequencer states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_CA    = 6'h02,
    ST_LAT   = 6'h04,
    ST_RDATA = 6'h08,
    ST_WDATA = 6'h10,
    ST_WAKE  = 6'h20
  } prc_state_type;

  // Command-address word as shifted in, first byte in the top bits.
  typedef struct packed {
    logic        readOp;
    logic        regSpace;
    logic        linearBurst;
    logic [44:0] addr;
  } prc_ca_type;

  // One written byte on its way to the array.
  typedef struct packed {
    logic [7:0] data;
    logic       masked;
    logic       first;
  } prc_beat_type;

endpackage

// ---- core/prc_fifo.sv ----
`timescale 1ns/1ps

// ==========================================================================
// Write buffer with a registered output stage.
// ==========================================================================
// DEPTH must be a power of two so the pointers wrap by themselves.
module prc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Filling side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Draining side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Storage words.
  logic [AW-1:0]    wrPtr;         // Next slot to fill.
  logic [AW-1:0]    rdPtr;         // Oldest stored word.
  logic [AW:0]      count;         // Words held in storage.
  logic [AW-1:0]    next_wrPtr;
  logic [AW-1:0]    next_rdPtr;
  logic [AW:0]      next_count;
  logic             next_outValid;
  logic [WIDTH-1:0] next_outData;
  logic             push;          // A word is accepted this cycle.
  logic             pop;           // A word moves to the output stage.

  // Full is honest: the output stage is extra room, not counted here.
  assign inReady = (count != (AW+1)'(DEPTH));
  assign push    = inValid && inReady;
  assign pop     = (count != '0) && (!outValid || outReady);

  // Pointer, count and output stage next values.
  always_comb begin
    next_wrPtr    = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr    = pop ? rdPtr + 1'b1 : rdPtr;
    next_count    = count + (AW+1)'(push) - (AW+1)'(pop);
    next_outData  = pop ? mem[rdPtr] : outData;
    if (pop) begin
      next_outValid = 1'b1;
    end else if (outReady) begin
      next_outValid = 1'b0;
    end else begin
      next_outValid = outValid;
    end
  end

  // Register the state; storage itself needs no reset.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPtr    <= '0;
      rdPtr    <= '0;
      count    <= '0;
      outValid <= 1'b0;
      outData  <= '0;
    end else begin
      wrPtr    <= next_wrPtr;
      rdPtr    <= next_rdPtr;
      count    <= next_count;
      outValid <= next_outValid;
      outData  <= next_outData;
    end
  end

  // Storage write.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule

// ---- core/prc_cfg_refresh.sv ----
`timescale 1ns/1ps
`include "prc_regs.svh"

// ==========================================================================
// ==========================================================================
module prc_cfg_refresh #(
  parameter int LATENCY_CLOCKS  = 7,
  parameter int HIGH_TEMP_GRADE = 0,
  parameter int REFRESH_CYCLES  = 8,
  parameter int FIFO_DEPTH      = 8
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Memory bus pins
  input  wire logic                 linkCk,
  input  wire logic                 clockComplement,
  input  wire logic                 selectN,
  input  wire logic                 hwResetN,
  input  wire logic [7:0]           dqIn,
  output logic      [7:0]           dqOut,
  output logic                      dqOeN,
  input  wire logic                 readWriteDataStrobeIn,
  output logic                      readWriteDataStrobeOut,
  output logic                      readWriteDataStrobeOeN,
  // Array side
  output logic                      beatValid,
  input  wire logic                 beatReady,
  output prc_pkg::prc_beat_type     beat,
  input  wire logic [7:0]           rdByte,
  output logic                      rdTake,
  output logic                      txnStart,
  output logic                      txnRead,
  output logic      [44:0]          txnAddr,
  // Status
  output logic      [15:0]          cfgRegisterOne,
  output logic                      refreshActive,
  output logic                      writeOverrun
);
  import prc_pkg::*;

  // ========================================================================
  // Constants.
  // ========================================================================
  localparam int INTERVAL_NS     = HIGH_TEMP_GRADE != 0 ? `PRC_MAX_SELECT_LOW_TIME_HIGH_NS : `PRC_MAX_SELECT_LOW_TIME_LOW_NS;
  // A longest time rounds down to whole cycles.
  localparam int INTERVAL_CYCLES = INTERVAL_NS * `PRC_SYS_CLK_MHZ / 1000;
  localparam logic [1:0] GRADE_CODE = HIGH_TEMP_GRADE != 0 ? `PRC_GRADE_HIGH_CODE : `PRC_GRADE_LOW_CODE;
  // The grade code replaces the two low bits of the reset image.
  localparam logic [15:0] CFG_RESET = (`PRC_CFG1_RESET & 16'hfffc) | {14'h0000, GRADE_CODE};
  localparam logic [7:0] LAT_EDGES  = 8'(2 * LATENCY_CLOCKS);

  // ========================================================================
  // Pin synchronisers.
  // ========================================================================
  logic [12:0] syncA;       // First stage, read only by the second.
  logic [12:0] syncB;       // Second stage, safe to use.
  logic        ckPrev;      // Link clock level one cycle ago.
  logic        sCk;
  logic        sCkc;
  logic        sCsN;
  logic        sResetN;
  logic        sStrobe;
  logic [7:0]  sDq;
  logic        ckLvl;       // Link clock as selected by the clock type.
  logic        linkEdge;    // Either edge of the link clock.
  logic        linkReset;   // System reset or reset pin.

  assign {sCk, sCkc, sCsN, sResetN, sStrobe, sDq} = syncB;
  // Data and clock share the same depth, so a sampled byte lines up with
  // the edge seen on the sampled clock.
  assign ckLvl     = cfgRegisterOne[`PRC_CLK_TYPE_BIT] ? sCk : (sCk & ~sCkc);
  assign linkEdge  = ckLvl != ckPrev;
  assign linkReset = rst || !sResetN;

  // Two flip-flops on every pin before any logic reads it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA  <= `PRC_SYNC_RESET;
      syncB  <= `PRC_SYNC_RESET;
      ckPrev <= 1'b0;
    end else begin
      syncA  <= {linkCk, clockComplement, selectN, hwResetN, readWriteDataStrobeIn, dqIn};
      syncB  <= syncA;
      ckPrev <= ckLvl;
    end
  end

  // ========================================================================
  // Refresh scheduler.
  // ========================================================================
  logic [15:0] timer;          // Cycles to the next refresh request.
  logic        pending;        // A refresh is due but not yet started.
  logic [7:0]  busyCnt;        // Cycles left of a running refresh.
  logic [15:0] next_timer;
  logic        next_pending;
  logic [7:0]  next_busyCnt;
  logic        next_refreshActive;
  logic        expire;
  logic        startRefresh;
  logic        noRefresh;

  assign expire       = timer == '0;
  assign noRefresh    = cfgRegisterOne[`PRC_PAR_MSB:`PRC_PAR_LSB] == `PRC_PAR_NONE;
  // Refresh only starts while the select is high, so it never starts inside an
  // access; sleep keeps it running so contents survive.
  assign startRefresh = pending && sCsN && !refreshActive;

  // Next values of the scheduler.
  always_comb begin
    next_timer         = expire ? 16'(INTERVAL_CYCLES - 1) : timer - 16'h0001;
    // A request arriving as the old one starts is kept.
    next_pending       = expire || (pending && !startRefresh);
    next_busyCnt       = busyCnt;
    next_refreshActive = refreshActive;
    if (startRefresh && !noRefresh) begin
      next_busyCnt       = 8'(REFRESH_CYCLES - 1);
      next_refreshActive = 1'b1;
    end else if (refreshActive) begin
      next_busyCnt       = busyCnt - 8'h01;
      next_refreshActive = busyCnt != 8'h00;
    end
  end

  // Refresh is held off for as long as either reset stands.
  always_ff @(posedge sys_clk) begin
    if (linkReset) begin
      timer         <= 16'(INTERVAL_CYCLES - 1);
      pending       <= 1'b0;
      busyCnt       <= 8'h00;
      refreshActive <= 1'b0;
    end else begin
      timer         <= next_timer;
      pending       <= next_pending;
      busyCnt       <= next_busyCnt;
      refreshActive <= next_refreshActive;
    end
  end

  // ========================================================================
  // Transaction sequencer and configuration register.
  // ========================================================================
  prc_state_type state;
  prc_state_type next_state;
  prc_ca_type    ca;           // Command-address word being received.
  prc_ca_type    caNext;       // Word including the byte on this edge.
  logic [7:0]    edgeCnt;      // Link edges within the current phase.
  logic          extra;        // Doubled latency for this access.
  logic          byteSel;      // Second byte of a pair.
  logic [15:0]   regData;      // Register word read or being written.
  logic [7:0]    latEnd;       // Last edge of initial latency.
  logic          extraNeed;    // Doubled latency needed at select fall.
  logic [7:0]    readByte;     // Byte for the next read edge.
  logic          fifoInReady;
  logic          pushValid;
  prc_beat_type  pushBeat;
  logic [7:0]    next_edgeCnt;
  logic          next_extra;
  logic          next_byteSel;
  logic [15:0]   next_regData;
  logic [15:0]   next_cfg;
  logic [7:0]    next_dqOut;
  logic          next_dqOeN;
  logic          next_strobeOut;
  logic          next_strobeOeN;
  logic          next_rdTake;
  logic          next_txnStart;
  logic          next_txnRead;
  logic [44:0]   next_txnAddr;
  logic          next_overrun;
  prc_ca_type    next_ca;

  // A full write buffer also asks for the longer latency, which holds the
  // host off long enough for the array side to drain.
  assign extraNeed = pending || refreshActive || !fifoInReady;
  assign latEnd    = (extra ? 8'(LAT_EDGES << 1) : LAT_EDGES) - 8'h01;
  assign caNext    = prc_ca_type'({ca[39:0], sDq});
  assign readByte  = ca.regSpace ? (byteSel ? regData[7:0] : regData[15:8]) : rdByte;
  assign pushBeat  = '{data: sDq, masked: sStrobe, first: !byteSel};

  // Next values of the sequencer, pins and configuration.
  always_comb begin
    next_state     = state;
    next_ca        = ca;
    next_edgeCnt   = edgeCnt;
    next_extra     = extra;
    next_byteSel   = byteSel;
    next_regData   = regData;
    next_cfg       = cfgRegisterOne;
    next_dqOut     = dqOut;
    next_dqOeN     = dqOeN;
    next_strobeOut = readWriteDataStrobeOut;
    next_strobeOeN = readWriteDataStrobeOeN;
    next_rdTake    = 1'b0;
    next_txnStart  = 1'b0;
    next_txnRead   = txnRead;
    next_txnAddr   = txnAddr;
    next_overrun   = writeOverrun;
    pushValid      = 1'b0;
    if (sCsN) begin
      // Select high: standby or sleep, both pins released.
      next_state     = ST_IDLE;
      next_dqOeN     = 1'b1;
      next_strobeOeN = 1'b1;
      next_strobeOut = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cfgRegisterOne[`PRC_SLEEP_BIT]) begin
            // This select pulse only wakes the device.
            next_cfg[`PRC_SLEEP_BIT] = 1'b0;
            next_state               = ST_WAKE;
          end else begin
            next_state     = ST_CA;
            next_edgeCnt   = 8'h00;
            next_extra     = extraNeed;
            next_strobeOeN = 1'b0;
            next_strobeOut = extraNeed;
          end
        end
        ST_CA: begin
          if (linkEdge) begin
            next_ca      = caNext;
            next_edgeCnt = edgeCnt + 8'h01;
            if (edgeCnt == `PRC_CA_EDGES - 8'h01) begin
              next_edgeCnt  = 8'h00;
              next_byteSel  = 1'b0;
              next_txnAddr  = caNext.addr;
              next_txnRead  = caNext.readOp;
              next_txnStart = !caNext.regSpace;
              next_regData  = (caNext.addr == `PRC_CFG1_ADDR) ? cfgRegisterOne : 16'h0000;
              if (!caNext.readOp && caNext.regSpace) begin
                next_state     = ST_WDATA;
                next_strobeOeN = 1'b1;
              end else if (!caNext.readOp) begin
                next_state     = ST_LAT;
                next_strobeOeN = 1'b1;
              end else begin
                next_state     = ST_LAT;
                next_strobeOut = 1'b0;
              end
            end
          end
        end
        ST_LAT: begin
          if (linkEdge) begin
            next_edgeCnt = edgeCnt + 8'h01;
            if (edgeCnt == latEnd) begin
              next_edgeCnt = 8'h00;
              if (ca.readOp) begin
                // First byte goes out with the first strobe rise.
                next_state     = ST_RDATA;
                next_dqOut     = readByte;
                next_dqOeN     = 1'b0;
                next_strobeOut = 1'b1;
                next_byteSel   = !byteSel;
                next_rdTake    = !ca.regSpace;
              end else begin
                next_state = ST_WDATA;
              end
            end
          end
        end
        ST_RDATA: begin
          if (linkEdge) begin
            next_dqOut     = readByte;
            next_strobeOut = !readWriteDataStrobeOut;
            next_byteSel   = !byteSel;
            next_rdTake    = !ca.regSpace;
          end
        end
        ST_WDATA: begin
          if (linkEdge) begin
            next_byteSel = 1'b1;
            if (ca.regSpace) begin
              // Register data: high byte first, mask never applied.
              if (!byteSel) begin
                next_regData = {sDq, regData[7:0]};
              end else if (ca.addr == `PRC_CFG1_ADDR) begin
                // Reserved bits and the interval code keep their values.
                next_cfg = (cfgRegisterOne & ~`PRC_CFG1_WRITE_MASK)
                         | ({regData[15:8], sDq} & `PRC_CFG1_WRITE_MASK);
              end
            end else begin
              pushValid = 1'b1;
              if (!fifoInReady) begin
                next_overrun = 1'b1;
              end
            end
          end
        end
        ST_WAKE: begin
          next_state = ST_WAKE;
        end
      endcase
    end
  end

  // Register the sequencer; either reset ends sleep and restores defaults.
  always_ff @(posedge sys_clk) begin
    if (linkReset) begin
      state                  <= ST_IDLE;
      ca                     <= '0;
      edgeCnt                <= 8'h00;
      extra                  <= 1'b0;
      byteSel                <= 1'b0;
      regData                <= 16'h0000;
      cfgRegisterOne         <= CFG_RESET;
      dqOut                  <= 8'h00;
      dqOeN                  <= 1'b1;
      readWriteDataStrobeOut <= 1'b0;
      readWriteDataStrobeOeN <= 1'b1;
      rdTake                 <= 1'b0;
      txnStart               <= 1'b0;
      txnRead                <= 1'b0;
      txnAddr                <= '0;
      writeOverrun           <= 1'b0;
    end else begin
      state                  <= next_state;
      ca                     <= next_ca;
      edgeCnt                <= next_edgeCnt;
      extra                  <= next_extra;
      byteSel                <= next_byteSel;
      regData                <= next_regData;
      cfgRegisterOne         <= next_cfg;
      dqOut                  <= next_dqOut;
      dqOeN                  <= next_dqOeN;
      readWriteDataStrobeOut <= next_strobeOut;
      readWriteDataStrobeOeN <= next_strobeOeN;
      rdTake                 <= next_rdTake;
      txnStart               <= next_txnStart;
      txnRead                <= next_txnRead;
      txnAddr                <= next_txnAddr;
      writeOverrun           <= next_overrun;
    end
  end

  // ========================================================================
  // Write buffer towards the array.
  // ========================================================================
  prc_fifo #(
    .WIDTH ($bits(prc_beat_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inValid  (pushValid),
    .inReady  (fifoInReady),
    .inData   (pushBeat),
    .outValid (beatValid),
    .outReady (beatReady),
    .outData  (beat)
  );
endmodule

// ---- verification/prc_cfg_refresh_sva.sv ----
`timescale 1ns/1ps
// ====================
// Port checks of the refresh and sleep configuration block.
module prc_cfg_refresh_sva #(
  parameter int HIGH_TEMP_GRADE = 0
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Watched pins and status
  input wire logic        selectN,
  input wire logic        dqOeN,
  input wire logic        readWriteDataStrobeOeN,
  input wire logic [15:0] cfgRegisterOne,
  input wire logic        refreshActive
);
  // The grade code is fixed by the build, never by a write.
  localparam logic [1:0] GRADE = (HIGH_TEMP_GRADE != 0) ? 2'h2 : 2'h1;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A select fall that opens a transaction, and one that only wakes.
  sequence selOpen; $fell(selectN) && !cfgRegisterOne[5]; endsequence
  sequence selWake; $fell(selectN) && cfgRegisterOne[5]; endsequence
  reset_idle_a: assert property (disable iff (1'b0) rst |=> dqOeN && readWriteDataStrobeOeN && !refreshActive)
    else $error("outputs not idle after reset");
  strobe_flag_a: assert property (selOpen |-> ##[1:8] !readWriteDataStrobeOeN)
    else $error("strobe not driven in command phase");
  wake_clear_a: assert property (selWake |-> ##[1:8] !cfgRegisterOne[5])
    else $error("sleep bit not cleared on wake");
  fixed_bits_a: assert property (cfgRegisterOne[15:7] == 9'h1ff)
    else $error("reserved bits changed");
  grade_code_a: assert property (cfgRegisterOne[1:0] == GRADE)
    else $error("interval code wrong");
  refresh_apart_a: assert property (refreshActive |-> dqOeN)
    else $error("refresh during read data");
  strobe_data_a: assert property (!dqOeN |-> !readWriteDataStrobeOeN)
    else $error("read data without strobe");
  standby_float_a: assert property (selectN [*5] |-> dqOeN && readWriteDataStrobeOeN)
    else $error("pins driven while deselected");
  no_refresh_a: assert property ($rose(refreshActive) |-> cfgRegisterOne[4:2] != 3'h4)
    else $error("refresh with region none");
endmodule

bind prc_cfg_refresh prc_cfg_refresh_sva #(.HIGH_TEMP_GRADE(HIGH_TEMP_GRADE)) u_sva (.sys_clk(sys_clk), .rst(rst),
  .selectN(selectN), .dqOeN(dqOeN), .readWriteDataStrobeOeN(readWriteDataStrobeOeN),
  .cfgRegisterOne(cfgRegisterOne), .refreshActive(refreshActive));

// ---- verification/prc_host_model.sv ----
`timescale 1ns/1ps
// ====================
// Host controller model; the link clock stands low between frames.
module prc_host_model (
  // Host pins
  output logic       linkCk,
  output logic       clockComplement,
  output logic       selectN,
  output logic       hwResetN,
  output logic [7:0] dqIn,
  output logic       readWriteDataStrobeIn,
  // Device drive
  input wire logic [7:0] dqOut,
  input wire logic       dqOeN,
  input wire logic       readWriteDataStrobeOut,
  input wire logic       readWriteDataStrobeOeN
);
  logic [7:0] hDq = 8'h00; // Host data value.
  logic hOe = 1'b0, hMask = 1'b0, hMaskOe = 1'b0;
  logic diffMode = 1'b0, extra = 1'b0; // Clock mode and latency flag.
  initial begin
    linkCk = 1'b0;
    selectN = 1'b1;
    hwResetN = 1'b1;
  end
  // Complement is biased high in single-ended mode so misuse shows.
  assign clockComplement = diffMode ? ~linkCk : 1'b1;
  // A released line shows the inverse, never the last value.
  assign dqIn = hOe ? hDq : (!dqOeN ? dqOut : ~hDq);
  assign readWriteDataStrobeIn = hMaskOe ? hMask : (!readWriteDataStrobeOeN ? readWriteDataStrobeOut : ~hMask);
  task automatic linkEdge(input logic [7:0] b);
    hDq = b;
    #12 linkCk = ~linkCk;
    #12;
  endtask
  task automatic startFrame(input logic rd, input logic rg, input logic [44:0] a);
    logic [47:0] ca;
    ca = {rd, rg, 1'b1, a};
    selectN = 1'b0;
    hOe = 1'b1;
    #24;
    for (int i = 5; i >= 0; i--) begin
      linkEdge(ca[i*8+:8]);
      if (i == 3) extra = !readWriteDataStrobeOeN && readWriteDataStrobeOut;
    end
  endtask
  // Frames stay far below the select-low limit.
  task automatic endFrame;
    hOe = 1'b0;
    hMaskOe = 1'b0;
    #24 selectN = 1'b1;
    #100;
  endtask
  task automatic regWrite(input logic [7:0] lo);
    hMaskOe = 1'b0;
    startFrame(1'b0, 1'b1, 45'h1);
    linkEdge(8'hff);
    linkEdge(lo);
    endFrame();
  endtask
  task automatic latency;
    hOe = 1'b0;
    repeat (extra ? 28 : 14) linkEdge(8'h00);
  endtask
  task automatic memWrite(input int n);
    startFrame(1'b0, 1'b0, 45'h40);
    latency();
    hOe = 1'b1;
    hMaskOe = 1'b1;
    for (int i = 0; i < n; i++) begin
      hMask = (i == 1);
      linkEdge(8'h10 + 8'(i));
    end
    endFrame();
  endtask
endmodule

// ---- verification/prc_cfg_refresh_tb.sv ----
`timescale 1ns/1ps
// ====================
// Bench: register writes, sleep, reset pin, read, write and refresh.
module prc_cfg_refresh_tb;
  import prc_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, beatReady = 1'b0;
  logic [7:0] rdByte = 8'h5a; // Array read byte.
  wire linkCk, ckc, selectN, hwResetN, strbIn, strbOut, strbOeN, dqOeN;
  wire [7:0] dqIn, dqOut;
  wire beatValid, rdTake, txnStart, txnRead, refreshActive, writeOverrun;
  wire [44:0] txnAddr;
  wire [15:0] cfg;
  prc_beat_type beat;
  int fails = 0, checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  int starts = 0; // Memory transactions decoded.
  // The array hands out a new byte each time one is taken.
  always @(negedge sys_clk) begin
    if (rdTake === 1'b1) rdByte <= rdByte + 8'h01;
    if (txnStart === 1'b1) starts++;
  end
  prc_cfg_refresh u_dut (.sys_clk(sys_clk), .rst(rst), .linkCk(linkCk), .clockComplement(ckc),
    .selectN(selectN), .hwResetN(hwResetN), .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN),
    .readWriteDataStrobeIn(strbIn), .readWriteDataStrobeOut(strbOut), .readWriteDataStrobeOeN(strbOeN),
    .beatValid(beatValid), .beatReady(beatReady), .beat(beat), .rdByte(rdByte), .rdTake(rdTake),
    .txnStart(txnStart), .txnRead(txnRead), .txnAddr(txnAddr), .cfgRegisterOne(cfg),
    .refreshActive(refreshActive), .writeOverrun(writeOverrun));
  prc_host_model u_host (.linkCk(linkCk), .clockComplement(ckc), .selectN(selectN), .hwResetN(hwResetN),
    .dqIn(dqIn), .readWriteDataStrobeIn(strbIn), .dqOut(dqOut), .dqOeN(dqOeN),
    .readWriteDataStrobeOut(strbOut), .readWriteDataStrobeOeN(strbOeN));
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic giveUp;
    fails++;
    report_and_stop();
  endtask
  task automatic t_regs;
    check(cfg, 16'hffc1);
    u_host.regWrite(8'h00);
    check(cfg, 16'hff81);
    u_host.diffMode = 1'b1;
    u_host.regWrite(8'hff);
    check(cfg, 16'hfffd);
    u_host.diffMode = 1'b0;
    u_host.selectN = 1'b0;
    #100 check(cfg, 16'hffdd);
    u_host.selectN = 1'b1;
    #100;
  endtask
  task automatic t_pin_reset;
    u_host.regWrite(8'hfc);
    u_host.hwResetN = 1'b0;
    #50 u_host.hwResetN = 1'b1;
    #50 check(cfg, 16'hffc1);
  endtask
  task automatic t_read;
    int k;
    u_host.startFrame(1'b1, 1'b0, 45'h123);
    u_host.latency();
    for (k = 0; k < 20 && dqOeN !== 1'b0; k++) @(negedge sys_clk);
    if (k == 20) giveUp();
    check(dqOut, 8'h5a);
    check(strbOut, 1'b1);
    check({txnRead, txnAddr}, {1'b1, 45'h123});
    u_host.linkEdge(8'h00);
    repeat (2) @(negedge sys_clk);
    check(dqOut, 8'h5b);
    check(strbOut, 1'b0);
    u_host.linkEdge(8'h00);
    u_host.endFrame();
  endtask
  task automatic t_write;
    int n;
    u_host.memWrite(12);
    check(writeOverrun, 1'b1);
    check(beat, {8'h10, 1'b0, 1'b1});
    @(negedge sys_clk) beatReady = 1'b1;
    n = 0;
    repeat (40) begin
      if (beatValid === 1'b1) begin
        if (n == 1) check(beat, {8'h11, 1'b1, 1'b0});
        n++;
      end
      @(negedge sys_clk);
    end
    check(n, 9);
    check(beatValid, 1'b0);
    check(starts, 2);
  endtask
  task automatic t_refresh;
    int seen;
    u_host.regWrite(8'hd0);
    check(cfg, 16'hffd1);
    seen = 0;
    repeat (1000) @(negedge sys_clk) seen += refreshActive;
    check(seen, 0);
    u_host.regWrite(8'hc0);
    for (seen = 0; seen < 1000 && refreshActive !== 1'b1; seen++) @(negedge sys_clk);
    if (seen == 1000) giveUp();
    check(refreshActive, 1'b1);
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    repeat (5) @(negedge sys_clk);
    t_regs();
    t_pin_reset();
    t_read();
    t_write();
    t_refresh();
    report_and_stop();
  end
endmodule
